/* bench/tb.sv */
// testbench: self-checking bench for the interrupt csr extensions
`timescale 1ns/1ps
module tb;
  import icx_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic csr_en = 1'b0;
  logic [11:0] csr_addr = 12'h000;
  icx_op_e csr_op = ICX_CSR_RW;
  logic csr_imm = 1'b0;
  logic [4:0] csr_uimm = 5'h00;
  icx_word_t csr_wdata = 32'h0000_0000;
  icx_word_t mtvec = 32'h0000_4000;
  icx_word_t mcause = 32'h8000_0012;
  icx_word_t mepc = 32'h0000_2468;
  icx_word_t msubm = 32'h0000_00c0;
  icx_word_t sp = 32'h2000_1000;
  logic [1:0] prev_priv = 2'h3;
  logic [7:0] prev_level = 8'h00;
  logic [7:0] machine_level = 8'h00;
  logic [7:0] user_active_level = 8'h00;
  logic next_pending = 1'b0;
  icx_word_t next_vector_entry = 32'h0000_0000;
  logic berr_valid = 1'b0;
  icx_berr_e berr_kind = ICX_BE_MEM;
  logic clint_mode = 1'b1;
  logic mie_berr = 1'b0;
  icx_word_t csr_rdata, tail_target, common_entry, store_addr, store_data;
  logic tail_jump, tail_irq_enable, tail_claim, berr_pending, berr_irq, berr_excp;
  logic [11:0] berr_cause;
  logic [4:0] berr_detail;
  logic deep_sleep, store_valid;
  int checked = 0;
  int miscompares = 0;
  int cycles = 0;
  icx_word_t r;

  icx_csr_unit #(.MAX_IRQ(64), .IS_RV64(1'b0)) u_icx_csr_unit (
    .ref_clk, .reset_n, .csr_en, .csr_addr, .csr_op, .csr_imm, .csr_uimm, .csr_wdata,
    .csr_rdata, .mtvec, .mcause, .mepc, .msubm, .sp, .prev_priv, .prev_level,
    .machine_level, .user_active_level, .next_pending, .next_vector_entry, .tail_jump,
    .tail_target, .tail_irq_enable, .tail_claim, .berr_valid, .berr_kind, .clint_mode,
    .mie_berr, .berr_pending, .berr_irq, .berr_excp, .berr_cause, .berr_detail,
    .common_entry, .deep_sleep, .store_valid, .store_addr, .store_data
  );

  always #25 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one access; result is read 1 ns after the taking edge
  task automatic csr(input logic [11:0] a, input icx_op_e op, input logic imm,
                     input logic [4:0] n, input icx_word_t wd, output icx_word_t rd);
    @(posedge ref_clk);
    csr_en <= 1'b1;
    csr_addr <= a;
    csr_op <= op;
    csr_imm <= imm;
    csr_uimm <= n;
    csr_wdata <= wd;
    @(posedge ref_clk);
    csr_en <= 1'b0;
    #1;
    rd = csr_rdata;
  endtask

  task automatic berr_pulse(input icx_berr_e k, output logic ex);
    @(posedge ref_clk);
    berr_valid <= 1'b1;
    berr_kind <= k;
    #1;
    ex = berr_excp;
    @(posedge ref_clk);
    berr_valid <= 1'b0;
    #1;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(deep_sleep, 1'b0, "sleep after reset");
    chk(berr_pending, 1'b0, "pending after reset");
    csr(CSR_SLEEP_DEPTH, ICX_CSR_RS, 1'b0, 5'h00, ZERO_WORD, r);
    chk(r, 32'h0000_0000, "sleep reset value");
    csr(CSR_MISC_CTL, ICX_CSR_RS, 1'b0, 5'h00, ZERO_WORD, r);
    chk(r[8], 1'b0, "misc bit reset");
    csr(12'h0123, ICX_CSR_RW, 1'b0, 5'h00, 32'hffff_ffff, r);
    csr(12'h0123, ICX_CSR_RS, 1'b0, 5'h00, ZERO_WORD, r);
    chk(r, 32'h0000_0000, "unmapped read");
  endtask

  task automatic t_sleep();
    csr(CSR_SLEEP_DEPTH, ICX_CSR_RW, 1'b0, 5'h00, 32'h0000_0001, r);
    chk(deep_sleep, 1'b1, "deep sleep set");
    csr(CSR_SLEEP_DEPTH, ICX_CSR_RS, 1'b0, 5'h00, ZERO_WORD, r);
    chk(r, 32'h0000_0001, "sleep readback");
    csr(CSR_SLEEP_DEPTH, ICX_CSR_RW, 1'b0, 5'h00, ZERO_WORD, r);
    chk(deep_sleep, 1'b0, "shallow sleep");
  endtask

  task automatic t_level();
    @(posedge ref_clk);
    machine_level <= 8'ha5;
    user_active_level <= 8'h3c;
    csr(CSR_ACT_LEVEL, ICX_CSR_RW, 1'b0, 5'h00, 32'hffff_ffff, r);
    chk(r, 32'ha500_003c, "active levels");
    csr(CSR_ACT_LEVEL, ICX_CSR_RS, 1'b0, 5'h00, ZERO_WORD, r);
    chk(r, 32'ha500_003c, "active levels after write");
  endtask

  task automatic t_common();
    csr(CSR_COMMON_BASE, ICX_CSR_RW, 1'b0, 5'h00, 32'h1234_5677, r);
    csr(CSR_COMMON_BASE, ICX_CSR_RS, 1'b0, 5'h00, ZERO_WORD, r);
    chk(r, 32'h1234_5675, "common base bit1 zero");
    chk(common_entry, 32'h1234_5674, "entry from field");
    csr(CSR_COMMON_BASE, ICX_CSR_RW, 1'b0, 5'h00, 32'h1234_5674, r);
    chk(common_entry, mtvec, "entry from mtvec");
  endtask

  task automatic t_vec();
    csr(CSR_VEC_BASE, ICX_CSR_RW, 1'b0, 5'h00, 32'hffff_ffff, r);
    csr(CSR_VEC_BASE, ICX_CSR_RS, 1'b0, 5'h00, ZERO_WORD, r);
    chk(r, 32'hffff_ff00, "vector base align");
    csr(CSR_VEC_BASE, ICX_CSR_RW, 1'b0, 5'h00, 32'h0000_0180, r);
    csr(CSR_VEC_BASE, ICX_CSR_RS, 1'b0, 5'h00, ZERO_WORD, r);
    chk(r, 32'h0000_0100, "vector base low bits");
  endtask

  task automatic t_push();
    logic [11:0] pa [3] = '{CSR_PUSH_SUBM, CSR_PUSH_CAUSE, CSR_PUSH_EPC};
    icx_word_t pd [3] = '{msubm, mcause, mepc};
    logic [4:0] ns [2] = '{5'h00, 5'h1f};
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 2; j++) begin
        csr(pa[i], ICX_CSR_RW, 1'b1, ns[j], ZERO_WORD, r);
        chk(store_valid, 1'b1, "push store");
        chk(store_addr, sp + {25'h0, ns[j], 2'b00}, "push addr");
        chk(store_data, pd[i], "push data");
      end
    end
    csr(CSR_PUSH_CAUSE, ICX_CSR_RW, 1'b0, 5'h01, ZERO_WORD, r);
    chk(store_valid, 1'b0, "push without immediate");
  endtask

  task automatic t_swap_priv();
    @(posedge ref_clk);
    prev_priv <= 2'h0;
    csr(CSR_SCRATCH, ICX_CSR_RW, 1'b0, 5'h00, 32'h1111_1111, r);
    csr(CSR_SWAP_PRIV, ICX_CSR_RW, 1'b0, 5'h00, 32'h2222_2222, r);
    chk(r, 32'h1111_1111, "priv swap result");
    csr(CSR_SCRATCH, ICX_CSR_RS, 1'b0, 5'h00, ZERO_WORD, r);
    chk(r, 32'h2222_2222, "priv swap scratch");
    @(posedge ref_clk);
    prev_priv <= PRIV_M;
    csr(CSR_SWAP_PRIV, ICX_CSR_RW, 1'b0, 5'h00, 32'h3333_3333, r);
    chk(r, 32'h3333_3333, "no swap from machine");
    csr(CSR_SCRATCH, ICX_CSR_RS, 1'b0, 5'h00, ZERO_WORD, r);
    chk(r, 32'h2222_2222, "scratch unchanged");
  endtask

  task automatic t_swap_level();
    logic [7:0] pl [4] = '{8'h00, 8'h01, 8'h00, 8'h02};
    logic [7:0] ml [4] = '{8'h00, 8'h00, 8'h01, 8'h03};
    logic sw [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    icx_word_t a;
    icx_word_t b;
    for (int i = 0; i < 4; i++) begin
      a = 32'ha000_0000 + i;
      b = 32'hb000_0000 + i;
      @(posedge ref_clk);
      prev_level <= pl[i];
      machine_level <= ml[i];
      csr(CSR_SCRATCH, ICX_CSR_RW, 1'b0, 5'h00, a, r);
      csr(CSR_SWAP_LEVEL, ICX_CSR_RW, 1'b0, 5'h00, b, r);
      chk(r, sw[i] ? a : b, "level swap result");
      csr(CSR_SCRATCH, ICX_CSR_RS, 1'b0, 5'h00, ZERO_WORD, r);
      chk(r, sw[i] ? b : a, "level swap scratch");
    end
  endtask

  task automatic t_berr();
    icx_berr_e ks [5] = '{ICX_BE_MEM, ICX_BE_PMP, ICX_BE_ECC, ICX_BE_SPMP, ICX_BE_COP};
    logic [4:0] ds [5] = '{5'h02, 5'h01, 5'h07, 5'h06, 5'h03};
    logic ex;
    berr_pulse(ICX_BE_ECC, ex);
    chk(ex, 1'b1, "exception form");
    chk(berr_pending, 1'b0, "no interrupt as exception");
    csr(CSR_MISC_CTL, ICX_CSR_RW, 1'b0, 5'h00, 32'h0000_0100, r);
    for (int i = 0; i < 5; i++) begin
      berr_pulse(ks[i], ex);
      chk(ex, 1'b0, "no exception as interrupt");
      chk(berr_pending, 1'b1, "interrupt pending");
      chk(berr_cause, 12'h012, "cause code");
      chk(berr_detail, ds[i], "cause detail");
      chk(berr_irq, 1'b0, "masked by machine enable");
    end
    @(posedge ref_clk);
    mie_berr <= 1'b1;
    #1;
    chk(berr_irq, 1'b1, "enabled interrupt");
    @(posedge ref_clk);
    clint_mode <= 1'b0;
    mie_berr <= 1'b0;
    berr_pulse(ICX_BE_PMP, ex);
    chk(berr_cause, 12'h012, "same id other mode");
    chk(berr_irq, 1'b1, "clic mode not gated by machine enable");
  endtask

  task automatic t_tail();
    @(posedge ref_clk);
    next_vector_entry <= 32'h8000_0200;
    next_pending <= 1'b1;
    csr(CSR_TAIL_JUMP, ICX_CSR_RW, 1'b0, 5'h00, ZERO_WORD, r);
    chk(tail_jump, 1'b1, "tail jump");
    chk(tail_claim, 1'b1, "tail claim");
    chk(tail_irq_enable, 1'b1, "tail enable");
    chk(tail_target, 32'h8000_0200, "tail target");
    @(posedge ref_clk);
    next_pending <= 1'b0;
    #1;
    chk(tail_jump, 1'b0, "tail pulse ends");
    chk(berr_pending, 1'b0, "claim clears pending");
    csr(CSR_TAIL_JUMP, ICX_CSR_RW, 1'b0, 5'h00, ZERO_WORD, r);
    chk(tail_jump, 1'b0, "no jump when idle");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_sleep();
    t_level();
    t_common();
    t_vec();
    t_push();
    t_swap_priv();
    t_swap_level();
    t_berr();
    t_tail();
    report_and_stop();
  end
endmodule

/* src/icx_berr_map.sv */
// module: maps a bus error type to interrupt id and cause detail
`timescale 1ns/1ps
module icx_berr_map
  import icx_pkg::*;
(
  // error type in
  input wire icx_berr_e kind,
  // coding out
  output logic [11:0] cause_code,
  output logic [4:0] detail
);
  always_comb begin
    cause_code = BUSERR_IRQ_ID; // [RL1] [RL7]
    unique case (kind)
      ICX_BE_MEM: detail = DET_MEM; // [RL2]
      ICX_BE_PMP: detail = DET_PMP; // [RL3]
      ICX_BE_ECC: detail = DET_ECC; // [RL4]
      ICX_BE_SPMP: detail = DET_SPMP; // [RL5]
      ICX_BE_COP: detail = DET_COP; // [RL6]
      default: detail = DET_MEM;
    endcase
  end
endmodule

/* src/icx_csr_unit.sv */
// module: interrupt support csrs, bus error interrupt, swaps and pushes
`timescale 1ns/1ps
// What this block does
// RL1 - bus errors as interrupts raise interrupt 18 and cause code 18
// RL2 - ordinary read or write bus error records detail 2
// RL3 - pmp violation bus error records detail 1
// RL4 - ecc error bus error records detail 7
// RL5 - supervisor protection violation records detail 6
// RL6 - coprocessor write-back bus error records detail 3
// RL7 - same interrupt id in both interrupt controller modes
// RL8 - software sets enable and edge trigger attribute in clic mode
// RL9 - clint mode gates bus error via machine enable and pending bits
// RL10 - vector base aligned by max interrupt count, rv64 twice rv32
// RL11 - active level shows machine level 31:24, user level 7:0
// RL12 - select bit chooses common entry from mtvec or address field
// RL13 - common base: address 31:2, bit 1 zero, bit 0 select
// RL14 - tail-chain access claims next, re-enables, jumps through vector
// RL15 - push-submode immediate n stores submode at sp plus n*4
// RL16 - push-cause immediate n stores mcause at sp plus n*4
// RL17 - push-return-pc immediate n stores mepc at sp plus n*4
// RL18 - privilege swap exchanges with mscratch when previous priv not machine
// RL19 - level swap exchanges when exactly one level is zero
// RL20 - sleep depth bit resets 0; 0 shallow, 1 deep
// RL21 - misc control bit 8 selects exception or interrupt bus error
// RL22 - vector base low bits below alignment forced zero
module icx_csr_unit
  import icx_pkg::*;
#(
  parameter int MAX_IRQ = 64,
  parameter bit IS_RV64 = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // csr access
  input wire logic csr_en,
  input wire logic [11:0] csr_addr,
  input wire icx_op_e csr_op,
  input wire logic csr_imm,
  input wire logic [4:0] csr_uimm,
  input wire icx_word_t csr_wdata,
  output icx_word_t csr_rdata,
  // core state
  input wire icx_word_t mtvec,
  input wire icx_word_t mcause,
  input wire icx_word_t mepc,
  input wire icx_word_t msubm,
  input wire icx_word_t sp,
  input wire logic [1:0] prev_priv,
  input wire logic [LVL_W-1:0] prev_level,
  input wire logic [LVL_W-1:0] machine_level,
  input wire logic [LVL_W-1:0] user_active_level,
  // tail chaining
  input wire logic next_pending,
  input wire icx_word_t next_vector_entry,
  output logic tail_jump,
  output icx_word_t tail_target,
  output logic tail_irq_enable,
  output logic tail_claim,
  // bus error events
  input wire logic berr_valid,
  input wire icx_berr_e berr_kind,
  input wire logic clint_mode,
  input wire logic mie_berr,
  output logic berr_pending,
  output logic berr_irq,
  output logic berr_excp,
  output logic [11:0] berr_cause,
  output logic [4:0] berr_detail,
  // handler entry and sleep
  output icx_word_t common_entry,
  output logic deep_sleep,
  // push stores
  output logic store_valid,
  output icx_word_t store_addr,
  output icx_word_t store_data
);
  // ------------------------------------------------------------
  // alignment
  // ------------------------------------------------------------
  function automatic int clog2i(int v);
    int r;
    r = 0;
    while ((1 << r) < v) r++;
    return r;
  endfunction

  localparam int IRQ_LOG2 = (clog2i(MAX_IRQ) > IRQ_MIN_LOG2) ? clog2i(MAX_IRQ) : IRQ_MIN_LOG2;
  localparam int ALIGN_LOG2 = ALIGN_MIN_LOG2 + IRQ_LOG2 - IRQ_MIN_LOG2 +
    (IS_RV64 ? RV64_EXTRA : 0);
  localparam icx_word_t VEC_MASK = ~((32'h0000_0001 << ALIGN_LOG2) - 32'h0000_0001);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic misc_buserr_q, misc_buserr_d;
  icx_word_t vec_base_q, vec_base_d;
  icx_word_t common_base_q, common_base_d;
  icx_word_t scratch_q, scratch_d;
  logic sleep_q, sleep_d;
  logic berr_pend_q, berr_pend_d;
  logic [11:0] cause_q, cause_d;
  logic [4:0] detail_q, detail_d;
  logic tail_q, tail_d;
  icx_word_t tail_tgt_q, tail_tgt_d;
  icx_word_t rdata_q, rdata_d;
  logic [11:0] map_code;
  logic [4:0] map_detail;
  icx_word_t src, old, newv;
  logic wr;

  icx_push_if push_ch();

  icx_berr_map u_map (
    .kind(berr_kind),
    .cause_code(map_code),
    .detail(map_detail)
  );

  icx_push_engine u_push (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .sp(sp),
    .push(push_ch)
  );

  function automatic icx_word_t apply_op(icx_op_e op, icx_word_t o, icx_word_t s);
    unique case (op)
      ICX_CSR_RW: apply_op = s;
      ICX_CSR_RS: apply_op = o | s;
      ICX_CSR_RC: apply_op = o & ~s;
      default: apply_op = o;
    endcase
  endfunction

  // ------------------------------------------------------------
  // csr access
  // ------------------------------------------------------------
  always_comb begin
    src = csr_imm ? {27'h000_0000, csr_uimm} : csr_wdata;
    wr = csr_en && (csr_op == ICX_CSR_RW || src != ZERO_WORD);
    misc_buserr_d = misc_buserr_q;
    vec_base_d = vec_base_q;
    common_base_d = common_base_q;
    scratch_d = scratch_q;
    sleep_d = sleep_q;
    tail_d = 1'b0;
    tail_tgt_d = tail_tgt_q;
    rdata_d = rdata_q;
    push_ch.req = 1'b0;
    push_ch.data = ZERO_WORD;
    push_ch.slot = csr_uimm;
    old = ZERO_WORD;
    unique case (csr_addr)
      CSR_MISC_CTL: old = {23'h00_0000, misc_buserr_q, 8'h00};
      CSR_VEC_BASE: old = vec_base_q;
      CSR_ACT_LEVEL: old = {machine_level, 16'h0000, user_active_level}; // [RL11]
      CSR_COMMON_BASE: old = common_base_q;
      CSR_SCRATCH: old = scratch_q;
      CSR_SLEEP_DEPTH: old = {31'h0000_0000, sleep_q};
      default: old = ZERO_WORD;
    endcase
    newv = apply_op(csr_op, old, src);
    if (csr_en) begin
      rdata_d = old;
      unique case (csr_addr)
        CSR_MISC_CTL: if (wr) misc_buserr_d = newv[MISC_BUSERR_BIT]; // [RL21]
        CSR_VEC_BASE: if (wr) vec_base_d = newv & VEC_MASK; // [RL10] [RL22]
        CSR_COMMON_BASE: if (wr) common_base_d = newv & COMMON_BASE_MASK |
          {31'h0000_0000, newv[ENTRY_SEL_BIT]}; // [RL13]
        CSR_SCRATCH: if (wr) scratch_d = newv;
        CSR_SLEEP_DEPTH: if (wr) sleep_d = newv[0]; // [RL20]
        CSR_SWAP_PRIV: begin
          if (prev_priv != PRIV_M) begin // [RL18]
            rdata_d = scratch_q;
            scratch_d = src;
          end else begin
            rdata_d = src;
          end
        end
        CSR_SWAP_LEVEL: begin
          if ((prev_level == '0) != (machine_level == '0)) begin // [RL19]
            rdata_d = scratch_q;
            scratch_d = src;
          end else begin
            rdata_d = src;
          end
        end
        CSR_TAIL_JUMP: begin
          rdata_d = next_pending ? next_vector_entry : ZERO_WORD; // [RL14]
          tail_d = next_pending;
          tail_tgt_d = next_vector_entry;
        end
        CSR_PUSH_SUBM: begin
          push_ch.req = csr_imm; // [RL15]
          push_ch.data = msubm;
        end
        CSR_PUSH_CAUSE: begin
          push_ch.req = csr_imm; // [RL16]
          push_ch.data = mcause;
        end
        CSR_PUSH_EPC: begin
          push_ch.req = csr_imm; // [RL17]
          push_ch.data = mepc;
        end
        CSR_ACT_LEVEL: rdata_d = old; // [RL11]
        default: rdata_d = ZERO_WORD;
      endcase
    end
  end

  // ------------------------------------------------------------
  // bus error reporting
  // ------------------------------------------------------------
  always_comb begin
    berr_pend_d = berr_pend_q;
    cause_d = cause_q;
    detail_d = detail_q;
    if (tail_q) berr_pend_d = 1'b0;
    if (berr_valid && misc_buserr_q) begin
      berr_pend_d = 1'b1; // set wins over claim
      cause_d = map_code; // [RL1]
      detail_d = map_detail;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      misc_buserr_q <= 1'b0;
      vec_base_q <= ZERO_WORD;
      common_base_q <= ZERO_WORD;
      scratch_q <= ZERO_WORD;
      sleep_q <= 1'b0; // [RL20]
      berr_pend_q <= 1'b0;
      cause_q <= 12'h000;
      detail_q <= 5'h00;
      tail_q <= 1'b0;
      tail_tgt_q <= ZERO_WORD;
      rdata_q <= ZERO_WORD;
    end else begin
      misc_buserr_q <= misc_buserr_d;
      vec_base_q <= vec_base_d;
      common_base_q <= common_base_d;
      scratch_q <= scratch_d;
      sleep_q <= sleep_d;
      berr_pend_q <= berr_pend_d;
      cause_q <= cause_d;
      detail_q <= detail_d;
      tail_q <= tail_d;
      tail_tgt_q <= tail_tgt_d;
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign csr_rdata = rdata_q;
  assign berr_pending = berr_pend_q;
  // clint gating by machine enable; clic applies its own enable and trigger
  assign berr_irq = berr_pend_q && (!clint_mode || mie_berr); // [RL9]
  assign berr_excp = berr_valid && !misc_buserr_q; // [RL21]
  assign berr_cause = cause_q;
  assign berr_detail = detail_q;
  assign common_entry = common_base_q[ENTRY_SEL_BIT] ?
    (common_base_q & COMMON_BASE_MASK) : mtvec; // [RL12]
  assign deep_sleep = sleep_q;
  assign tail_jump = tail_q;
  assign tail_target = tail_tgt_q;
  assign tail_irq_enable = tail_q; // [RL14]
  assign tail_claim = tail_q;
  assign store_valid = push_ch.store_valid;
  assign store_addr = push_ch.store_addr;
  assign store_data = push_ch.store_data;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_berr_int;
    berr_valid && misc_buserr_q;
  endsequence

  AST_BERR_ID: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL1]
    s_berr_int |=> berr_pending && berr_cause == 12'h012)
    else $error("bus error interrupt id not 18");
  AST_DET_PMP: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL3]
    (s_berr_int and (berr_kind == ICX_BE_PMP)) |=> berr_detail == 5'h01)
    else $error("pmp detail wrong");
  AST_DET_ECC: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL4]
    (s_berr_int and (berr_kind == ICX_BE_ECC)) |=> berr_detail == 5'h07)
    else $error("ecc detail wrong");
  AST_EXCP_MODE: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL21]
    berr_valid && !misc_buserr_q |-> berr_excp ##1 ($stable(berr_pending) || $past(tail_q)))
    else $error("exception mode bus error raised interrupt");
  AST_CLINT_GATE: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL9]
    clint_mode && !mie_berr |-> !berr_irq)
    else $error("clint gate failed");
  AST_ALIGN: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL10]
    (vec_base_q & ~VEC_MASK) == ZERO_WORD)
    else $error("vector base misaligned");
  AST_BIT1_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL13]
    common_base_q[ENTRY_RSVD_BIT] == 1'b0)
    else $error("common base bit 1 set");
  AST_PRIV_SWAP: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL18]
    csr_en && csr_addr == CSR_SWAP_PRIV && prev_priv != PRIV_M
    |=> csr_rdata == $past(scratch_q) && scratch_q == $past(src))
    else $error("privilege swap wrong");
  AST_LVL_KEEP: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL19]
    csr_en && csr_addr == CSR_SWAP_LEVEL && ((prev_level == '0) == (machine_level == '0))
    |=> csr_rdata == $past(src) && $stable(scratch_q))
    else $error("level swap changed scratch");
  AST_ENTRY: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL12]
    !common_base_q[ENTRY_SEL_BIT] |-> common_entry == mtvec)
    else $error("common entry not from mtvec");
endmodule

/* src/icx_pkg.sv */
// package: constants, csr numbers and types for the interrupt csr extensions
package icx_pkg;
  localparam int XLEN = 32;
  typedef logic [XLEN-1:0] icx_word_t;
  // csr numbers handled by this block (indices on the csr port)
  localparam logic [11:0] CSR_MISC_CTL = 12'h07D0;
  localparam logic [11:0] CSR_VEC_BASE = 12'h0307;
  localparam logic [11:0] CSR_ACT_LEVEL = 12'h0346;
  localparam logic [11:0] CSR_COMMON_BASE = 12'h07EC;
  localparam logic [11:0] CSR_TAIL_JUMP = 12'h07ED;
  localparam logic [11:0] CSR_PUSH_SUBM = 12'h07EB;
  localparam logic [11:0] CSR_PUSH_CAUSE = 12'h07EE;
  localparam logic [11:0] CSR_PUSH_EPC = 12'h07EF;
  localparam logic [11:0] CSR_SWAP_PRIV = 12'h0348;
  localparam logic [11:0] CSR_SWAP_LEVEL = 12'h0349;
  localparam logic [11:0] CSR_SLEEP_DEPTH = 12'h0811;
  localparam logic [11:0] CSR_SCRATCH = 12'h0340;
  // fields
  localparam int MISC_BUSERR_BIT = 8;
  localparam int ENTRY_SEL_BIT = 0;
  localparam int ENTRY_RSVD_BIT = 1;
  localparam int MIL_LSB = 24;
  localparam int LVL_W = 8;
  localparam int PUSH_SCALE_SH = 2;
  localparam logic [1:0] PRIV_M = 2'h3;
  localparam icx_word_t ZERO_WORD = 32'h0000_0000;
  localparam icx_word_t COMMON_BASE_MASK = 32'hFFFF_FFFC;
  // bus error coding
  localparam logic [11:0] BUSERR_IRQ_ID = 12'h0012;
  localparam logic [4:0] DET_MEM = 5'h02;
  localparam logic [4:0] DET_PMP = 5'h01;
  localparam logic [4:0] DET_ECC = 5'h07;
  localparam logic [4:0] DET_SPMP = 5'h06;
  localparam logic [4:0] DET_COP = 5'h03;
  // vector base alignment: log2 of 64 bytes is 6, one step per doubling above 16
  localparam int ALIGN_MIN_LOG2 = 6;
  localparam int IRQ_MIN_LOG2 = 4;
  localparam int RV64_EXTRA = 1;
  typedef enum logic [2:0] {
    ICX_BE_MEM, ICX_BE_PMP, ICX_BE_ECC, ICX_BE_SPMP, ICX_BE_COP
  } icx_berr_e;
  typedef enum logic [1:0] {ICX_CSR_RW, ICX_CSR_RS, ICX_CSR_RC} icx_op_e;
endpackage

/* src/icx_push_engine.sv */
// module: turns a push request into a registered store at sp + n*4
`timescale 1ns/1ps
module icx_push_engine
  import icx_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // stack pointer
  input wire icx_word_t sp,
  // push channel
  icx_push_if.eng push
);
  logic valid_q, valid_d;
  icx_word_t addr_q, addr_d, data_q, data_d;

  function automatic icx_word_t slot_addr(icx_word_t base, logic [4:0] n);
    slot_addr = base + {25'h000_0000, n, 2'b00};
  endfunction

  always_comb begin
    valid_d = push.req;
    addr_d = addr_q;
    data_d = data_q;
    if (push.req) begin
      addr_d = slot_addr(sp, push.slot); // [RL15] [RL16] [RL17]
      data_d = push.data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      valid_q <= 1'b0;
      addr_q <= ZERO_WORD;
      data_q <= ZERO_WORD;
    end else begin
      valid_q <= valid_d;
      addr_q <= addr_d;
      data_q <= data_d;
    end
  end

  assign push.store_valid = valid_q;
  assign push.store_addr = addr_q;
  assign push.store_data = data_q;

  AST_PUSH_ADDR: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RL15]
    push.req |=> push.store_valid && push.store_addr == $past(sp) + 32'($past(push.slot)) * 4)
    else $error("push store address wrong");
endmodule

/* src/icx_push_if.sv */
// interface: memory store request carried from csr unit to push engine
`timescale 1ns/1ps
interface icx_push_if;
  import icx_pkg::*;
  logic req;
  icx_word_t data;
  logic [4:0] slot;
  logic store_valid;
  icx_word_t store_addr;
  icx_word_t store_data;
  modport csr (output req, output data, output slot);
  modport eng (input req, input data, input slot,
    output store_valid, output store_addr, output store_data);
endinterface
